// [logic/scaled_move_pkg.sv]
// constants, types and helpers for the scaled store and byte load unit
// assumes a 32-bit classic wishbone register port and a 32-bit data memory port
package scaled_move_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_STATUS_WORD = 8'h00;
	localparam logic [7:0] OFS_MODIFIER    = 8'h04;
	localparam logic [7:0] OFS_COMMAND     = 8'h08;
	localparam logic [7:0] OFS_IWORD0      = 8'h0c;
	localparam logic [7:0] OFS_IWORD1      = 8'h10;
	localparam logic [7:0] OFS_IWORD2      = 8'h14;
	localparam logic [7:0] OFS_UNIT_STAT   = 8'h18;
	localparam logic [7:0] OFS_REG_SEL     = 8'h1c;
	localparam logic [7:0] OFS_REG_LO      = 8'h20;
	localparam logic [7:0] OFS_REG_HI      = 8'h24;

	// status word fields
	localparam int SR_SAT_MODE   = 2;
	localparam int SR_SCALE_LO   = 4;
	localparam int SR_SCALE_FLAG = 6;
	localparam int SR_EXC_STACK  = 18;
	localparam logic [31:0] SR_RESET   = 32'h0000_0000;
	localparam logic [31:0] MODIFIER_CONTROL_REG_RESET = 32'h0000_0000;

	// command register fields
	localparam int CMD_OP_LO     = 0;
	localparam int CMD_FORM_LO   = 2;
	localparam int CMD_DATA_HIGH = 5;
	localparam int CMD_PTR_HIGH  = 6;
	localparam int CMD_GO        = 7;
	localparam int SERIAL_BIT    = 14;

	// unit status fields
	localparam int STAT_BUSY   = 0;
	localparam int STAT_SERIAL = 1;
	localparam int STAT_CYC_LO = 4;

	// register window indices
	localparam logic [5:0] REGSEL_SP_NORM = 6'h24;
	localparam logic [5:0] REGSEL_SP_EXC  = 6'h25;

	// instruction timing in cycles
	localparam logic [2:0] CYC_ABS      = 3'h1;
	localparam logic [2:0] CYC_OFFSET   = 3'h2;
	localparam logic [2:0] CYC_EA       = 3'h1;
	localparam logic [2:0] CYC_N0_EXTRA = 3'h1;

	// clamp limits and scale-flag magnitude window
	localparam logic [15:0] WORD_MAX = 16'h7fff;
	localparam logic [15:0] WORD_MIN = 16'h8000;
	localparam logic [31:0] LONG_MAX = 32'h7fff_ffff;
	localparam logic [31:0] LONG_MIN = 32'h8000_0000;
	localparam logic [31:0] MAG_QUARTER       = 32'h2000_0000;
	localparam logic [31:0] MAG_THREE_QUARTER = 32'h6000_0000;

	// addressing mode codes
	localparam logic [2:0] EA_PTR_N0   = 3'b000;
	localparam logic [2:0] EA_POST_DEC = 3'b001;
	localparam logic [2:0] EA_INDIRECT = 3'b010;
	localparam logic [2:0] EA_POST_INC = 3'b011;
	localparam logic [1:0] SHORT_POST_INC = 2'b00;
	localparam logic [1:0] SHORT_POST_DEC = 2'b01;
	localparam logic [1:0] SHORT_PTR_N0   = 2'b10;

	// access sizes
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_WORD = 2'h1;
	localparam logic [1:0] SIZE_LONG = 2'h2;

	typedef enum logic [1:0] {
		OP_STORE_WORD = 2'b00,
		OP_STORE_LONG = 2'b01,
		OP_LOAD_BYTE  = 2'b10
	} op_t;

	typedef enum logic [2:0] {
		FORM_ABS_SHORT  = 3'b000,
		FORM_ABS_LONG   = 3'b001,
		FORM_PTR_OFFSET = 3'b010,
		FORM_EA         = 3'b011,
		FORM_SP_OFFSET  = 3'b100
	} form_t;

	typedef enum logic [1:0] {
		SCALE_NONE = 2'b00,
		SCALE_DOWN = 2'b01,
		SCALE_UP   = 2'b10
	} scale_t;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_ADDR = 2'b01,
		S_WAIT = 2'b10,
		S_MEM  = 2'b11
	} state_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic        write;
		logic [1:0]  size;
	} mem_req_t;

	function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] val,
		input logic [3:0] sel);
		for (int b = 0; b < 4; b++) begin
			mergeBytes[8*b +: 8] = sel[b] ? val[8*b +: 8] : old[8*b +: 8];
		end
	endfunction

	// reverse-carry add for bit-reversed pointer stepping
	function automatic logic [31:0] revAdd(input logic [31:0] a, input logic [31:0] b);
		logic [31:0] ra;
		logic [31:0] rb;
		logic [31:0] s;
		for (int i = 0; i < 32; i++) begin
			ra[i] = a[31-i];
			rb[i] = b[31-i];
		end
		s = ra + rb;
		for (int i = 0; i < 32; i++) begin
			revAdd[i] = s[31-i];
		end
	endfunction

endpackage

// [logic/scaled_move_unit.sv]
// execution unit for the scaled word and long stores and the unsigned byte load
// assumes software loads instruction words over wishbone and memory answers with memAck
`timescale 1ns/1ps

// Summary of operation
// - word store writes upper half of source, scaled, clamped when its limit tag is set.
// - with saturation mode set, stores skip scaling whatever the scale mode field says.
// - scale mode field selects pass, shift up one bit, or shift down one bit.
// - after a scaled store set scale flag when written magnitude is in [0.25, 0.75).
// - long store writes a 32-bit scaled clamped word through the indirect modes.
// - word store addresses: short, long absolute, pointer+offset, indirect modes, stack+offset.
// - exception stack select bit picks which stack pointer bases stack-relative forms.
// - modifier control bits apply only when updating pointer registers 0 to 7.
// - indirect mode field: base+N0, post-dec, indirect, post-inc, post-add N0..N3.
// - pointer plus offset register 0 form costs one extra cycle.
// - absolute forms one cycle, offset forms two cycles, indirect form one cycle.
// - data register field picks registers 0-7; 8-15 need the data prefix.
// - pointer register field picks registers 0-7; 8-15 need the pointer prefix.
// - one opcode bit of single-word forms is the serial grouping indicator.
// - long store follows the same scaling and limit tag clamping as the word store.
// - byte load puts the byte in bits 7:0 and zeros every higher bit.
// - byte load clears the limit tag of the destination register.
// - byte load destination codes 0-7 are data registers, 8-15 pointer registers.
// - byte load short mode: post-inc, post-dec, base+N0, plain indirect.
// - byte load addresses: short, long absolute, pointer+offset, indirect, stack+offset.
module scaled_move_unit (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	// wishbone register slave
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	// data memory
	output scaled_move_pkg::mem_req_t memReq,
	output logic                      memValid,
	input  wire logic                 memAck,
	input  wire logic [7:0]           memRdata
);

	logic [31:0]              statusWord;
	logic [31:0]              modCtl;
	logic [31:0]              iw0;
	logic [31:0]              iw1;
	logic [31:0]              iw2;
	logic [5:0]               regSel;
	logic [39:0]              dataReg [16];
	logic [15:0]              limTag;
	logic [31:0]              ptrReg [16];
	logic [31:0]              offReg [4];
	logic [31:0]              spNorm;
	logic [31:0]              spExc;
	scaled_move_pkg::op_t     op;
	scaled_move_pkg::form_t   form;
	scaled_move_pkg::state_t  state;
	logic                     dataHigh;
	logic                     ptrHigh;
	logic                     serialGroup;
	logic [2:0]               lastCycles;
	logic [2:0]               waitLeft;
	logic                     scaleHitReg;

	logic                     busReq;
	logic                     busWr;
	logic [7:0]               wordAdr;
	logic                     idle;
	logic                     startCmd;
	logic [31:0]              readData;
	logic [39:0]              winData;
	logic [31:0]              winPtr;
	logic                     winIsData;
	logic                     winIsPtr;
	logic                     winIsOff;

	logic [3:0]               rn;
	logic [3:0]               srcIdx;
	logic [3:0]               dstIdx;
	logic                     dstIsPtr;
	logic [2:0]               eaMode;
	logic [31:0]              s15off;
	logic [31:0]              step;
	logic [31:0]              amount;
	logic [31:0]              eaAddr;
	logic [31:0]              ptrNext;
	logic                     ptrUpd;
	logic                     useRev;
	logic [2:0]               cycles;
	logic [39:0]              srcVal;
	logic                     srcLim;
	logic [40:0]              scaled;
	logic                     fits;
	logic [15:0]              clampWord;
	logic [31:0]              clampLong;
	logic [31:0]              outVal;
	logic [31:0]              mag;
	logic                     scaleHit;

	// bus decode; writes take effect on the edge that carries ack
	assign busReq   = wb_cyc_i & wb_stb_i;
	assign busWr    = busReq & wb_we_i & wb_ack_o;
	assign wordAdr  = {wb_adr_i[7:2], 2'b00};
	assign idle     = (state == scaled_move_pkg::S_IDLE);
	assign memValid = (state == scaled_move_pkg::S_MEM);
	assign startCmd = busWr && idle && wordAdr == scaled_move_pkg::OFS_COMMAND && wb_sel_i[0]
		&& wb_dat_i[scaled_move_pkg::CMD_GO] && wb_dat_i[scaled_move_pkg::CMD_OP_LO +: 2] != 2'b11
		&& wb_dat_i[scaled_move_pkg::CMD_FORM_LO +: 3] <= 3'h4;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= busReq & ~wb_ack_o;
			if (busReq && !wb_ack_o) begin
				wb_dat_o <= readData;
			end
		end
	end

	// register window selection
	assign winIsData = (regSel[5:4] == 2'b00);
	assign winIsPtr  = (regSel[5:4] == 2'b01);
	assign winIsOff  = (regSel[5:2] == 4'b1000);
	assign winData   = dataReg[regSel[3:0]];
	assign winPtr    = winIsPtr ? ptrReg[regSel[3:0]] : winIsOff ? offReg[regSel[1:0]] :
		regSel == scaled_move_pkg::REGSEL_SP_NORM ? spNorm :
		regSel == scaled_move_pkg::REGSEL_SP_EXC ? spExc : 32'h0000_0000;

	always_comb begin
		readData = 32'h0000_0000;
		unique case (wordAdr)
			scaled_move_pkg::OFS_STATUS_WORD: readData = statusWord;
			scaled_move_pkg::OFS_MODIFIER:    readData = modCtl;
			scaled_move_pkg::OFS_COMMAND:     readData = {24'h0, 1'b0, ptrHigh, dataHigh, form, op};
			scaled_move_pkg::OFS_IWORD0:      readData = iw0;
			scaled_move_pkg::OFS_IWORD1:      readData = iw1;
			scaled_move_pkg::OFS_IWORD2:      readData = iw2;
			scaled_move_pkg::OFS_UNIT_STAT:   readData = {25'h0, lastCycles, 2'b00, serialGroup, ~idle};
			scaled_move_pkg::OFS_REG_SEL:     readData = {26'h0, regSel};
			scaled_move_pkg::OFS_REG_LO:      readData = winIsData ? winData[31:0] : winPtr;
			scaled_move_pkg::OFS_REG_HI:      readData = winIsData ?
				{23'h0, limTag[regSel[3:0]], winData[39:32]} : 32'h0000_0000;
			default:                          readData = 32'h0000_0000;
		endcase
	end

	// status word: hardware set of the scale flag wins over a software write
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			statusWord <= scaled_move_pkg::SR_RESET;
			modCtl     <= scaled_move_pkg::MODIFIER_CONTROL_REG_RESET;
			regSel     <= 6'h00;
		end else begin
			if (busWr && wordAdr == scaled_move_pkg::OFS_STATUS_WORD) begin
				statusWord <= scaled_move_pkg::mergeBytes(statusWord, wb_dat_i, wb_sel_i);
			end
			if (memValid && memAck && op != scaled_move_pkg::OP_LOAD_BYTE && scaleHitReg) begin
				statusWord[scaled_move_pkg::SR_SCALE_FLAG] <= 1'b1;
			end
			if (busWr && wordAdr == scaled_move_pkg::OFS_MODIFIER) begin
				modCtl <= scaled_move_pkg::mergeBytes(modCtl, wb_dat_i, wb_sel_i);
			end
			if (busWr && wordAdr == scaled_move_pkg::OFS_REG_SEL && wb_sel_i[0]) begin
				regSel <= wb_dat_i[5:0];
			end
		end
	end

	// instruction words and command; refused while busy
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			iw0         <= 32'h0000_0000;
			iw1         <= 32'h0000_0000;
			iw2         <= 32'h0000_0000;
			op          <= scaled_move_pkg::OP_STORE_WORD;
			form        <= scaled_move_pkg::FORM_ABS_SHORT;
			dataHigh    <= 1'b0;
			ptrHigh     <= 1'b0;
			serialGroup <= 1'b0;
		end else begin
			if (busWr && idle && wordAdr == scaled_move_pkg::OFS_IWORD0) begin
				iw0 <= scaled_move_pkg::mergeBytes(iw0, wb_dat_i, wb_sel_i);
			end
			if (busWr && idle && wordAdr == scaled_move_pkg::OFS_IWORD1) begin
				iw1 <= scaled_move_pkg::mergeBytes(iw1, wb_dat_i, wb_sel_i);
			end
			if (busWr && idle && wordAdr == scaled_move_pkg::OFS_IWORD2) begin
				iw2 <= scaled_move_pkg::mergeBytes(iw2, wb_dat_i, wb_sel_i);
			end
			if (startCmd) begin
				op          <= scaled_move_pkg::op_t'(wb_dat_i[scaled_move_pkg::CMD_OP_LO +: 2]);
				form        <= scaled_move_pkg::form_t'(wb_dat_i[scaled_move_pkg::CMD_FORM_LO +: 3]);
				dataHigh    <= wb_dat_i[scaled_move_pkg::CMD_DATA_HIGH];
				ptrHigh     <= wb_dat_i[scaled_move_pkg::CMD_PTR_HIGH];
				serialGroup <= iw0[scaled_move_pkg::SERIAL_BIT];
			end
		end
	end

	// operand decode, address generation and scaling
	always_comb begin
		rn       = {ptrHigh, iw0[2:0]};
		srcIdx   = {dataHigh, iw0[10:8]};
		dstIsPtr = iw0[11];
		dstIdx   = {dstIsPtr ? ptrHigh : dataHigh, iw0[10:8]};
		s15off   = {{17{iw0[6]}}, iw0[6:5], iw1[12:0]};
		unique case (op)
			scaled_move_pkg::OP_LOAD_BYTE:  step = 32'h0000_0001;
			scaled_move_pkg::OP_STORE_LONG: step = 32'h0000_0004;
			default:                        step = 32'h0000_0002;
		endcase
		eaMode = iw0[5:3];
		if (op == scaled_move_pkg::OP_LOAD_BYTE) begin
			unique case (iw0[4:3])
				scaled_move_pkg::SHORT_POST_INC: eaMode = scaled_move_pkg::EA_POST_INC;
				scaled_move_pkg::SHORT_POST_DEC: eaMode = scaled_move_pkg::EA_POST_DEC;
				scaled_move_pkg::SHORT_PTR_N0:   eaMode = scaled_move_pkg::EA_PTR_N0;
				default:                         eaMode = scaled_move_pkg::EA_INDIRECT;
			endcase
		end
		eaAddr = ptrReg[rn];
		amount = 32'h0000_0000;
		ptrUpd = 1'b0;
		cycles = scaled_move_pkg::CYC_ABS;
		unique case (form)
			scaled_move_pkg::FORM_ABS_SHORT: eaAddr = {16'h0, iw0[7:5], iw1[12:0]};
			scaled_move_pkg::FORM_ABS_LONG:  eaAddr = {iw0[4:3], iw2[13:0], iw0[7:5], iw1[12:0]};
			scaled_move_pkg::FORM_PTR_OFFSET: begin
				eaAddr = ptrReg[rn] + s15off;
				cycles = scaled_move_pkg::CYC_OFFSET;
			end
			scaled_move_pkg::FORM_SP_OFFSET: begin
				eaAddr = (statusWord[scaled_move_pkg::SR_EXC_STACK] ? spExc : spNorm) + s15off;
				cycles = scaled_move_pkg::CYC_OFFSET;
			end
			default: begin
				cycles = scaled_move_pkg::CYC_EA;
				unique case (eaMode)
					scaled_move_pkg::EA_PTR_N0: begin
						eaAddr = ptrReg[rn] + offReg[0];
						cycles = scaled_move_pkg::CYC_EA + scaled_move_pkg::CYC_N0_EXTRA;
					end
					scaled_move_pkg::EA_POST_DEC: begin
						ptrUpd = 1'b1;
						amount = 32'h0000_0000 - step;
					end
					scaled_move_pkg::EA_INDIRECT: ptrUpd = 1'b0;
					scaled_move_pkg::EA_POST_INC: begin
						ptrUpd = 1'b1;
						amount = step;
					end
					default: begin
						ptrUpd = 1'b1;
						amount = offReg[eaMode[1:0]];
					end
				endcase
			end
		endcase
		useRev  = !rn[3] && modCtl[{rn[2:0], 2'b11}];
		ptrNext = useRev ? scaled_move_pkg::revAdd(ptrReg[rn], amount) : ptrReg[rn] + amount;
		srcVal  = dataReg[srcIdx];
		srcLim  = limTag[srcIdx];
		if (statusWord[scaled_move_pkg::SR_SAT_MODE]) begin
			scaled = {srcVal[39], srcVal};
		end else begin
			unique case (scaled_move_pkg::scale_t'(statusWord[scaled_move_pkg::SR_SCALE_LO +: 2]))
				scaled_move_pkg::SCALE_UP:   scaled = {srcVal, 1'b0};
				scaled_move_pkg::SCALE_DOWN: scaled = {{2{srcVal[39]}}, srcVal[39:1]};
				default:                     scaled = {srcVal[39], srcVal};
			endcase
		end
		fits      = (&scaled[40:31]) | ~(|scaled[40:31]);
		clampWord = (srcLim && !fits) ? (srcVal[39] ? scaled_move_pkg::WORD_MIN :
			scaled_move_pkg::WORD_MAX) : scaled[31:16];
		clampLong = (srcLim && !fits) ? (srcVal[39] ? scaled_move_pkg::LONG_MIN :
			scaled_move_pkg::LONG_MAX) : scaled[31:0];
		outVal    = (op == scaled_move_pkg::OP_STORE_LONG) ? clampLong : {clampWord, 16'h0000};
		mag       = outVal[31] ? (32'h0000_0000 - outVal) : outVal;
		scaleHit  = mag >= scaled_move_pkg::MAG_QUARTER && mag < scaled_move_pkg::MAG_THREE_QUARTER;
	end

	// sequencer
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state    <= scaled_move_pkg::S_IDLE;
			waitLeft <= 3'h0;
		end else begin
			unique case (state)
				scaled_move_pkg::S_IDLE: begin
					if (startCmd) begin
						state <= scaled_move_pkg::S_ADDR;
					end
				end
				scaled_move_pkg::S_ADDR: begin
					waitLeft <= cycles - 3'h1;
					state    <= (cycles == 3'h1) ? scaled_move_pkg::S_MEM : scaled_move_pkg::S_WAIT;
				end
				scaled_move_pkg::S_WAIT: begin
					waitLeft <= waitLeft - 3'h1;
					if (waitLeft <= 3'h1) begin
						state <= scaled_move_pkg::S_MEM;
					end
				end
				scaled_move_pkg::S_MEM: begin
					if (memAck) begin
						state <= scaled_move_pkg::S_IDLE;
					end
				end
			endcase
		end
	end

	// memory request, captured when the address is formed
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			memReq      <= '0;
			scaleHitReg <= 1'b0;
			lastCycles  <= 3'h0;
		end else if (state == scaled_move_pkg::S_ADDR) begin
			memReq.addr  <= eaAddr;
			memReq.write <= (op != scaled_move_pkg::OP_LOAD_BYTE);
			memReq.wdata <= (op == scaled_move_pkg::OP_STORE_LONG) ? clampLong : {16'h0000, clampWord};
			memReq.size  <= (op == scaled_move_pkg::OP_LOAD_BYTE) ? scaled_move_pkg::SIZE_BYTE :
				(op == scaled_move_pkg::OP_STORE_LONG) ? scaled_move_pkg::SIZE_LONG :
				scaled_move_pkg::SIZE_WORD;
			scaleHitReg  <= scaleHit;
			lastCycles   <= cycles;
		end
	end

	// register files: software window, pointer update, load write-back
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 16; i++) begin
				dataReg[i] <= 40'h00_0000_0000;
				ptrReg[i]  <= 32'h0000_0000;
			end
			for (int i = 0; i < 4; i++) begin
				offReg[i] <= 32'h0000_0000;
			end
			limTag <= 16'h0000;
			spNorm <= 32'h0000_0000;
			spExc  <= 32'h0000_0000;
		end else begin
			if (busWr && wordAdr == scaled_move_pkg::OFS_REG_LO) begin
				if (winIsData) begin
					dataReg[regSel[3:0]][31:0] <= scaled_move_pkg::mergeBytes(winData[31:0],
						wb_dat_i, wb_sel_i);
				end else if (winIsPtr) begin
					ptrReg[regSel[3:0]] <= scaled_move_pkg::mergeBytes(winPtr, wb_dat_i, wb_sel_i);
				end else if (winIsOff) begin
					offReg[regSel[1:0]] <= scaled_move_pkg::mergeBytes(winPtr, wb_dat_i, wb_sel_i);
				end else if (regSel == scaled_move_pkg::REGSEL_SP_NORM) begin
					spNorm <= scaled_move_pkg::mergeBytes(winPtr, wb_dat_i, wb_sel_i);
				end else if (regSel == scaled_move_pkg::REGSEL_SP_EXC) begin
					spExc <= scaled_move_pkg::mergeBytes(winPtr, wb_dat_i, wb_sel_i);
				end
			end
			if (busWr && wordAdr == scaled_move_pkg::OFS_REG_HI && winIsData) begin
				if (wb_sel_i[0]) begin
					dataReg[regSel[3:0]][39:32] <= wb_dat_i[7:0];
				end
				if (wb_sel_i[1]) begin
					limTag[regSel[3:0]] <= wb_dat_i[8];
				end
			end
			if (state == scaled_move_pkg::S_ADDR && form == scaled_move_pkg::FORM_EA && ptrUpd) begin
				ptrReg[rn] <= ptrNext;
			end
			if (memValid && memAck && op == scaled_move_pkg::OP_LOAD_BYTE) begin
				if (dstIsPtr) begin
					ptrReg[dstIdx] <= {24'h00_0000, memRdata};
				end else begin
					dataReg[dstIdx] <= {32'h0000_0000, memRdata};
					limTag[dstIdx]  <= 1'b0;
				end
			end
		end
	end

	default clocking cbk @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence seqAddrN0;
		state == scaled_move_pkg::S_ADDR && form == scaled_move_pkg::FORM_EA
			&& eaMode == scaled_move_pkg::EA_PTR_N0;
	endsequence

	sequence seqOneWait;
		state == scaled_move_pkg::S_WAIT
			##1 state == scaled_move_pkg::S_MEM;
	endsequence

	chk_n0_extra_cycle: assert property (seqAddrN0 |=> seqOneWait)
		else $error("base plus N0 form did not take one extra cycle");
	chk_abs_one_cycle: assert property (state == scaled_move_pkg::S_ADDR
		&& (form == scaled_move_pkg::FORM_ABS_SHORT || form == scaled_move_pkg::FORM_ABS_LONG)
		|=> state == scaled_move_pkg::S_MEM)
		else $error("absolute form did not issue after one cycle");
	chk_sat_positive: assert property (state == scaled_move_pkg::S_ADDR
		&& op == scaled_move_pkg::OP_STORE_WORD && srcLim && !fits && !srcVal[39]
		|=> memReq.wdata[15:0] == 16'h7fff)
		else $error("positive overflow not clamped to word maximum");
	chk_sm_no_scale: assert property (state == scaled_move_pkg::S_ADDR && !srcLim
		&& op == scaled_move_pkg::OP_STORE_WORD && statusWord[scaled_move_pkg::SR_SAT_MODE]
		|=> memReq.wdata[15:0] == $past(srcVal[31:16]))
		else $error("store scaled while saturation mode set");
	chk_scale_flag: assert property (memValid && memAck && op != scaled_move_pkg::OP_LOAD_BYTE
		&& scaleHitReg |=> statusWord[scaled_move_pkg::SR_SCALE_FLAG])
		else $error("scale flag not set after store");
	chk_load_zero_ext: assert property (memValid && memAck && !dstIsPtr
		&& op == scaled_move_pkg::OP_LOAD_BYTE
		|=> dataReg[dstIdx] == {32'h0000_0000, $past(memRdata)} && !limTag[dstIdx])
		else $error("byte load not zero extended or tag not cleared");
	chk_stack_select: assert property (state == scaled_move_pkg::S_ADDR
		&& form == scaled_move_pkg::FORM_SP_OFFSET && statusWord[scaled_move_pkg::SR_EXC_STACK]
		|=> memReq.addr == $past(spExc) + $past(s15off))
		else $error("stack relative form used the wrong stack pointer");
	chk_post_inc: assert property (state == scaled_move_pkg::S_ADDR
		&& form == scaled_move_pkg::FORM_EA && eaMode == scaled_move_pkg::EA_POST_INC && !useRev
		|=> ptrReg[rn] == $past(ptrReg[rn]) + $past(step)
		&& memReq.addr == $past(ptrReg[rn]))
		else $error("post increment did not step pointer by access size");

endmodule // scaled_move_unit

// [verification/mem_model.sv]
// data memory model for the unit's memory port, answering after a bench-set delay
// assumes memReq holds while memValid is high
`timescale 1ns/1ps
module mem_model (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_b,
	// unit side
	input  wire scaled_move_pkg::mem_req_t memReq,
	input  wire logic                      memValid,
	output logic                           memAck,
	output logic      [7:0]                memRdata,
	// bench side
	input  wire logic [1:0]                lat,
	input  wire logic [7:0]                rdByte,
	output scaled_move_pkg::mem_req_t      seen
);
	logic [1:0] cnt;
	// byte only meaningful with ack, inverted otherwise
	assign memRdata = memAck ? rdByte : ~rdByte;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 2'h0;
			memAck <= 1'b0;
			seen <= '0;
		end else if (memValid && !memAck && cnt == lat) begin
			memAck <= 1'b1;
			seen <= memReq;
			cnt <= 2'h0;
		end else begin
			memAck <= 1'b0;
			cnt <= (memValid && !memAck) ? cnt + 2'h1 : 2'h0;
		end
	end
endmodule // mem_model

// [verification/scaled_move_unit_test.sv]
// self-checking bench for scaled_move_unit through its wishbone port
// assumes mem_model on the data memory port
`timescale 1ns/1ps
module scaled_move_unit_test;
	logic                      clk, rst_b, cyc, stb, we, memValid, memAck, ack;
	logic [7:0]                adr, memRdata, rdByte;
	logic [31:0]               dat, rdat, q;
	logic [1:0]                lat;
	scaled_move_pkg::mem_req_t memReq, seen;
	int                        nMismatch, testsRun;
	scaled_move_unit scaled_move_unit_i (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .memReq(memReq), .memValid(memValid), .memAck(memAck), .memRdata(memRdata));
	mem_model mem_model_i (.clk(clk), .rst_b(rst_b), .memReq(memReq), .memValid(memValid),
		.memAck(memAck), .memRdata(memRdata), .lat(lat), .rdByte(rdByte), .seen(seen));
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", testsRun, nMismatch);
		if (nMismatch == 0 && testsRun > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		testsRun++;
		if (s !== e) begin
			nMismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1) begin
			nMismatch++;
			report_and_stop;
		end
		@(posedge clk);
	endtask
	task automatic rg(input logic [31:0] sel, input logic [31:0] lo, input logic [31:0] hi);
		bus(1, 8'h1c, sel);
		bus(1, 8'h20, lo);
		bus(1, 8'h24, hi);
	endtask
	task automatic run(input logic [7:0] cmd, input logic [31:0] w0, input logic [31:0] w1);
		bus(1, 8'h0c, w0);
		bus(1, 8'h10, w1);
		bus(1, 8'h08, {24'h0, cmd | 8'h80});
		q = 32'h1;
		for (int i = 0; i < 30 && q[0] !== 1'b0; i++) bus(0, 8'h18, 0);
		if (q[0] !== 1'b0) begin
			nMismatch++;
			report_and_stop;
		end
	endtask
	task automatic st(input logic [7:0] cmd, input logic [31:0] sr, w0, w1, ea, ed,
		input logic [2:0] cy, input logic fl);
		lat <= lat + 2'h1;
		bus(1, 8'h00, sr);
		run(cmd, w0, w1);
		chk("cycles", {29'h0, q[6:4]}, {29'h0, cy});
		chk("addr", seen.addr, ea);
		chk("data", cmd[0] ? seen.wdata : {16'h0, seen.wdata[15:0]}, ed);
		bus(0, 8'h00, 0);
		chk("flag", {31'h0, q[6]}, {31'h0, fl});
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		{rst_b, cyc, stb, we, adr, dat, lat, rdByte, q} = '0;
		nMismatch = 0;
		testsRun = 0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		bus(0, 8'h00, 0);
		chk("status reset", q, scaled_move_pkg::SR_RESET);
		bus(0, 8'h40, 0);
		chk("unmapped", q, 32'h0);
		rg(0, 32'h1234_0000, 0);
		rg(1, 32'h8000_0000, 32'h100);
		rg(2, 0, 32'h1ff);
		rg(3, 32'hffff_ffff, 32'h1ff);
		rg(16, 32'h54, 0);
		rg(32, 4, 0);
		rg(36, 32'h100, 0);
		rg(37, 32'h200, 0);
		st(8'h00, 0, 0, 32'h50, 32'h50, 32'h1234, 1, 0);
		st(8'h00, 32'h10, 0, 32'h52, 32'h52, 32'h091a, 1, 0);
		st(8'h00, 32'h20, 0, 32'h54, 32'h54, 32'h2468, 1, 1);
		st(8'h00, 32'h24, 0, 32'h56, 32'h56, 32'h1234, 1, 0);
		st(8'h04, 0, 32'h100, 32'h58, 32'h58, 32'h7fff, 1, 0);
		st(8'h08, 0, 32'h200, 4, 32'h58, 32'h8000, 2, 0);
		st(8'h10, 0, 0, 4, 32'h104, 32'h1234, 2, 0);
		st(8'h10, 32'h4_0000, 0, 4, 32'h204, 32'h1234, 2, 0);
		st(8'h0d, 0, 32'h110, 0, 32'h54, 32'h7fff_ffff, 1, 0);
		st(8'h0d, 0, 32'h100, 0, 32'h58, 32'h7fff_ffff, 2, 0);
		st(8'h0d, 0, 32'h120, 0, 32'h54, 32'h7fff_ffff, 1, 0);
		st(8'h0d, 32'h20, 32'h010, 0, 32'h58, 32'h2468_0000, 1, 1);
		rdByte <= 8'hf8;
		run(8'h02, 32'h300, 32'h53);
		chk("load addr", seen.addr, 32'h53);
		rg(3, 32'hffff_ffff, 32'h1ff);
		bus(0, 8'h1c, 0);
		bus(1, 8'h1c, 3);
		run(8'h02, 32'h300, 32'h53);
		bus(0, 8'h20, 0);
		chk("load low", q, 32'hf8);
		bus(0, 8'h24, 0);
		chk("load high", q, 32'h0);
		run(8'h0e, 32'hb18, 0);
		chk("load indirect", seen.addr, 32'h58);
		bus(1, 8'h1c, 19);
		bus(0, 8'h20, 0);
		chk("load pointer", q, 32'hf8);
		run(8'h0e, 32'h4b00, 0);
		chk("serial bit", {31'h0, q[1]}, 32'h1);
		chk("post inc addr", seen.addr, 32'h58);
		bus(1, 8'h04, 32'h8);
		run(8'h0e, 32'hb00, 0);
		chk("reverse addr", seen.addr, 32'h59);
		bus(1, 8'h1c, 16);
		bus(0, 8'h20, 0);
		chk("reverse step", q, 32'h58);
		report_and_stop;
	end
endmodule // scaled_move_unit_test
